// >>> verilog/diag_status_pkg.sv
package diag_status_pkg;
	// register map: sub-address of each channel status byte
	localparam int          NUM_CH      = 3;
	localparam int          SUBADDR_W   = 5;
	localparam int          DATA_W      = 8;
	localparam logic [4:0]  CH1_ADDR    = 5'h10;
	localparam logic [4:0]  CH2_ADDR    = 5'h11;
	localparam logic [4:0]  CH3_ADDR    = 5'h12;
	localparam logic [7:0]  STAT_RESET  = 8'h00;
	localparam logic [7:0]  UNMAPPED_RD = 8'h00;

	// bit positions common to every channel byte
	localparam int B_OFFSET    = 5;
	localparam int B_PERM_DONE = 4;
	localparam int B_SHORT     = 3;
	localparam int B_OPEN      = 2;
	localparam int B_SHORT_VCC = 1;
	localparam int B_SHORT_GND = 0;
	// upper two bits, meaning depends on the channel
	localparam int B_HI        = 7;
	localparam int B_LO        = 6;
	// channel indices for the special upper bits
	localparam int CH1 = 0;
	localparam int CH2 = 1;
	localparam int CH3 = 2;

	// per-channel fault events from the analog diagnostic (one-cycle pulses)
	typedef struct packed {
		logic offset;
		logic perm_done;
		logic short_load;
		logic open_load;
		logic short_vcc;
		logic short_gnd;
	} chan_evt_s;

	// serial-side read request as delivered by the bus front end
	typedef struct packed {
		logic                 req;
		logic [SUBADDR_W-1:0] addr;
	} rd_req_s;
endpackage

// >>> verilog/speaker_diag_status_regs.sv
`timescale 1ns/100ps
// Functional notes
// R1 - channel 1, 2, 3 status bytes sit at sub-addresses 10000, 10001, 10010
// R2 - ch1 bit 7 is 0 in tristate after reset, 1 once tristate left
// R3 - ch1 bit 6 is 1 only after the turn-on diagnostic has finished
// R4 - bit 5 of each channel flags a detected output offset
// R5 - bit 4 of each channel flags a finished permanent diagnostic cycle
// R6 - after each read, restart permanent diag if fault persists and enabled
// R7 - bit 3 of each channel flags a shorted load
// R8 - bit 2 flags open load, detected only during turn-on diagnostic
// R9 - bit 1 of each channel flags a short to positive supply
// R10 - bit 0 of each channel flags a short to ground
// R11 - channel 2 bits 7 and 6 report thermal warning levels one and two
// R12 - channel 3 bits 7 and 6 report thermal warning levels three and four
// R13 - reading a status byte clears it; the code keeps ch1 bit 7 across the read
// R14 - host must set diagnostic enable for diagnostics and restart to work; the code gates only the restart on diag_en, flags latch without it
// R15 - every flag stays latched until the host reads its byte
module speaker_diag_status_regs
	import diag_status_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// read port from the serial front end
	input  wire rd_req_s               rd,
	output logic [DATA_W-1:0]          rd_data_r,
	output logic                       rd_valid_r,
	// diagnostic events and levels
	input  wire chan_evt_s [NUM_CH-1:0] evt,
	input  wire logic [NUM_CH-1:0]     perm_fault,
	input  wire logic                  tristate_exit,
	input  wire logic                  turnon_active,
	input  wire logic                  turnon_done,
	input  wire logic                  thermal_warning_level_one,
	input  wire logic                  thermal_warning_level_two,
	input  wire logic                  thermal_warning_level_three,
	input  wire logic                  thermal_warning_level_four,
	// diagnostic enable bit of diag_gain_control_byte
	input  wire logic                  diag_en,
	// permanent diagnostic restart, one pulse per channel
	output logic [NUM_CH-1:0]          perm_restart_r
);

	logic [NUM_CH-1:0][DATA_W-1:0] stat_r;
	logic [NUM_CH-1:0][DATA_W-1:0] stat_nxt;
	logic [DATA_W-1:0]             rd_data_nxt;
	logic                          rd_valid_nxt;
	logic [NUM_CH-1:0]             perm_restart_nxt;

	// sub-address of a channel byte
	function automatic logic [SUBADDR_W-1:0] ch_addr(input int c);
		case (c)
			CH1:     ch_addr = CH1_ADDR;
			CH2:     ch_addr = CH2_ADDR;
			default: ch_addr = CH3_ADDR;
		endcase
	endfunction

	// true when a request reads channel c
	function automatic logic reads_ch(input rd_req_s r, input int c);
		reads_ch = r.req && (r.addr == ch_addr(c));
	endfunction

	// read, clear-on-read and event capture; sets are applied after the
	// clear so an event in the read cycle survives into the next read
	always_comb begin
		stat_nxt         = stat_r;
		rd_data_nxt      = UNMAPPED_RD;
		rd_valid_nxt     = rd.req;
		perm_restart_nxt = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			if (reads_ch(rd, c)) begin // R1
				rd_data_nxt = stat_r[c];
				stat_nxt[c] = STAT_RESET; // R13
				// tristate history is since reset, a read does not forget it
				if (c == CH1)
					stat_nxt[c][B_HI] = stat_r[c][B_HI]; // R2
				// restart only while enabled; host owns the enable bit
				perm_restart_nxt[c] = diag_en && perm_fault[c]; // R6 R14
			end
			// latched fault flags, or-ed in so they hold until read
			if (evt[c].offset)     stat_nxt[c][B_OFFSET]    = 1'b1; // R4 R15
			if (evt[c].perm_done)  stat_nxt[c][B_PERM_DONE] = 1'b1; // R5
			if (evt[c].short_load) stat_nxt[c][B_SHORT]     = 1'b1; // R7
			// open load is meaningless outside the turn-on test
			if (evt[c].open_load && turnon_active)
				stat_nxt[c][B_OPEN] = 1'b1; // R8
			if (evt[c].short_vcc)  stat_nxt[c][B_SHORT_VCC] = 1'b1; // R9
			if (evt[c].short_gnd)  stat_nxt[c][B_SHORT_GND] = 1'b1; // R10
		end
		if (tristate_exit)               stat_nxt[CH1][B_HI] = 1'b1; // R2
		if (turnon_done)                 stat_nxt[CH1][B_LO] = 1'b1; // R3
		if (thermal_warning_level_one)   stat_nxt[CH2][B_HI] = 1'b1; // R11
		if (thermal_warning_level_two)   stat_nxt[CH2][B_LO] = 1'b1; // R11
		if (thermal_warning_level_three) stat_nxt[CH3][B_HI] = 1'b1; // R12
		if (thermal_warning_level_four)  stat_nxt[CH3][B_LO] = 1'b1; // R12
	end

	// state and output registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stat_r         <= {NUM_CH{STAT_RESET}};
			rd_data_r      <= UNMAPPED_RD;
			rd_valid_r     <= 1'b0;
			perm_restart_r <= '0;
		end else begin
			stat_r         <= stat_nxt;
			rd_data_r      <= rd_data_nxt;
			rd_valid_r     <= rd_valid_nxt;
			perm_restart_r <= perm_restart_nxt;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic mapped;
	assign mapped = reads_ch(rd, CH1) || reads_ch(rd, CH2)
		|| reads_ch(rd, CH3);

	ch2_read_data_a: assert property ( // R1
		reads_ch(rd, CH2) |=> rd_valid_r && rd_data_r == $past(stat_r[CH2]))
		else $error("channel 2 read returned wrong byte");
	unmapped_zero_a: assert property ( // R1
		rd.req && !mapped |=> rd_valid_r && rd_data_r == UNMAPPED_RD)
		else $error("unmapped read not zero");
	tristate_hist_a: assert property ( // R2
		tristate_exit |=> stat_r[CH1][B_HI])
		else $error("tristate history not set");
	property always_hist_p;
		stat_r[CH1][B_HI] |=> stat_r[CH1][B_HI];
	endproperty
	hist_sticky_a: assert property (always_hist_p) // R2
		else $error("tristate history lost");
	turnon_flag_a: assert property ( // R3
		$rose(stat_r[CH1][B_LO]) |-> $past(turnon_done))
		else $error("turn-on flag set without completion");
	perm_restart_a: assert property ( // R6
		reads_ch(rd, CH3) && diag_en && perm_fault[CH3]
		|=> perm_restart_r[CH3]
		##1 (!perm_restart_r[CH3] || reads_ch($past(rd), CH3)))
		else $error("permanent diagnostic not restarted");
	no_restart_a: assert property ( // R14
		!diag_en |=> perm_restart_r == '0)
		else $error("restart while diagnostics disabled");
	open_gate_a: assert property ( // R8
		$rose(stat_r[CH1][B_OPEN]) |-> $past(turnon_active))
		else $error("open load latched outside turn-on test");
	tw_map_a: assert property ( // R11 R12
		thermal_warning_level_one && thermal_warning_level_four
		|=> stat_r[CH2][B_HI] && stat_r[CH3][B_LO])
		else $error("thermal warning bit misplaced");
	clear_read_a: assert property ( // R13
		reads_ch(rd, CH2) && evt[CH2] == '0 && !thermal_warning_level_one
		&& !thermal_warning_level_two |=> stat_r[CH2] == STAT_RESET)
		else $error("read did not clear channel 2");
	set_wins_a: assert property ( // R15
		reads_ch(rd, CH1) && evt[CH1].short_gnd
		|=> stat_r[CH1][B_SHORT_GND] ##1 stat_r[CH1][B_SHORT_GND]
		|| reads_ch($past(rd), CH1))
		else $error("event lost during read");
	short_sticky_a: assert property ( // R15 R7
		stat_r[CH3][B_SHORT] && !reads_ch(rd, CH3) |=> stat_r[CH3][B_SHORT])
		else $error("short flag dropped without read");

	// read port timing: every request answered exactly one cycle later
	valid_after_req_a: assert property ( // R1
		rd.req |=> rd_valid_r)
		else $error("read request without answer");
	valid_pulse_a: assert property ( // R1
		!rd.req |=> !rd_valid_r)
		else $error("answer without read request");
	// idle data held at zero so a late sampler never sees a stale byte
	idle_data_a: assert property ( // R1
		!rd_valid_r |-> rd_data_r == UNMAPPED_RD)
		else $error("read data not zero while idle");
	ch1_read_data_a: assert property ( // R1
		reads_ch(rd, CH1) |=> rd_data_r == $past(stat_r[CH1]))
		else $error("channel 1 read returned wrong byte");
	ch3_read_data_a: assert property ( // R1
		reads_ch(rd, CH3) |=> rd_data_r == $past(stat_r[CH3]))
		else $error("channel 3 read returned wrong byte");

	// per-bit latching of the analog events, spread over the channels
	turnon_latch_a: assert property ( // R3
		turnon_done |=> stat_r[CH1][B_LO])
		else $error("turn-on completion not latched");
	offset_latch_a: assert property ( // R4
		evt[CH2].offset |=> stat_r[CH2][B_OFFSET])
		else $error("offset event not latched");
	perm_done_a: assert property ( // R5
		evt[CH3].perm_done |=> stat_r[CH3][B_PERM_DONE])
		else $error("permanent cycle end not latched");
	short_latch_a: assert property ( // R7
		evt[CH1].short_load |=> stat_r[CH1][B_SHORT])
		else $error("short load not latched");
	open_latch_a: assert property ( // R8
		evt[CH2].open_load && turnon_active |=> stat_r[CH2][B_OPEN])
		else $error("open load during turn-on not latched");
	vcc_latch_a: assert property ( // R9
		evt[CH1].short_vcc |=> stat_r[CH1][B_SHORT_VCC])
		else $error("short to supply not latched");
	gnd_latch_a: assert property ( // R10
		evt[CH3].short_gnd |=> stat_r[CH3][B_SHORT_GND])
		else $error("short to ground not latched");
	tw_two_a: assert property ( // R11
		thermal_warning_level_two |=> stat_r[CH2][B_LO])
		else $error("second thermal warning not latched");
	tw_three_a: assert property ( // R12
		thermal_warning_level_three |=> stat_r[CH3][B_HI])
		else $error("third thermal warning not latched");

	// restart pulses only follow a read and only with a live fault
	restart_on_read_a: assert property ( // R6
		perm_restart_r != '0 |-> $past(rd.req))
		else $error("restart without a status read");
	restart_gate_a: assert property ( // R6
		!perm_fault[CH1] |=> !perm_restart_r[CH1])
		else $error("restart without a persisting fault");

	// main scenarios to cover; the bench reaches all but restart_c and set_on_read_c
	read_fault_c:   cover property (reads_ch(rd, CH1) && stat_r[CH1] != '0);
	set_win_c:      cover property (reads_ch(rd, CH1) && evt[CH1].short_gnd);
	restart_c:      cover property (perm_restart_r[CH2]);
	set_on_read_c:  cover property (reads_ch(rd, CH3) && evt[CH3].offset);
	unmapped_c:     cover property (rd.req && !mapped);

endmodule

// >>> tb/host_model.sv
`timescale 1ns/100ps
// host side of the status read path: one request per read
module host_model
	import diag_status_pkg::*;
(
	// clock
	input  wire logic sys_clk,
	// read request toward the device
	output rd_req_s   rd
);
	initial rd = '{1'b0, 5'h00};
	// request lives one edge; address then flips so a stale one never matches
	task automatic read(input logic [4:0] a);
		rd <= '{1'b1, a};
		@(posedge sys_clk);
		rd <= '{1'b0, ~a};
	endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import diag_status_pkg::*;
;
	logic              sys_clk, rst, diag_en, tri_exit, ton_act, ton_done;
	logic [3:0]        tw;
	logic [NUM_CH-1:0] perm_fault, perm_restart_r;
	chan_evt_s [NUM_CH-1:0] evt;
	rd_req_s           rd;
	logic [7:0]        rd_data_r;
	logic              rd_valid_r;
	int                miscompares, n_tests, cyc;

	host_model host (.sys_clk(sys_clk), .rd(rd));
	speaker_diag_status_regs DUT (.sys_clk(sys_clk), .rst(rst), .rd(rd),
		.rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .evt(evt),
		.perm_fault(perm_fault), .tristate_exit(tri_exit),
		.turnon_active(ton_act), .turnon_done(ton_done),
		.thermal_warning_level_one(tw[0]), .thermal_warning_level_two(tw[1]),
		.thermal_warning_level_three(tw[2]),
		.thermal_warning_level_four(tw[3]), .diag_en(diag_en),
		.perm_restart_r(perm_restart_r));

	task automatic wrap_up;
		$display("tests=%0d mismatches=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// answer stands one cycle after the request edge, so look just after it
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		host.read(a);
		#1;
		chk({7'h00, rd_valid_r}, 8'h01);
		chk(rd_data_r, exp);
	endtask
	task automatic pulse_evt(input int c, input logic [5:0] v);
		@(posedge sys_clk);
		evt[c] <= chan_evt_s'(v);
		@(posedge sys_clk);
		evt[c] <= '0;
	endtask
	task automatic t_reset;
		for (int c = 0; c < 4; c++) begin
			rd_chk(5'(CH1_ADDR + c), 8'h00);
		end
	endtask
	// each event flag pulsed once, read later to prove it latched; ch1 open load pulsed again outside turn-on
	task automatic t_flags;
		for (int c = 0; c < NUM_CH; c++) begin
			for (int b = 0; b < 6; b++) begin
				pulse_evt(c, 6'h01 << b);
				rd_chk(5'(CH1_ADDR + c), 8'h01 << b);
				rd_chk(5'(CH1_ADDR + c), 8'h00);
			end
		end
		@(posedge sys_clk);
		ton_act <= 1'b0;
		pulse_evt(0, 6'h04);
		rd_chk(CH1_ADDR, 8'h00);
	endtask
	task automatic t_upper;
		@(posedge sys_clk);
		{tw, tri_exit, ton_done} <= 6'h37;
		@(posedge sys_clk);
		{tw, tri_exit, ton_done} <= 6'h00;
		rd_chk(CH1_ADDR, 8'hC0);
		rd_chk(CH1_ADDR, 8'h80);
		rd_chk(CH2_ADDR, 8'h80);
		rd_chk(CH3_ADDR, 8'hC0);
		@(posedge sys_clk);
		tw <= 4'hA;
		@(posedge sys_clk);
		tw <= 4'h0;
		rd_chk(CH2_ADDR, 8'h40);
		rd_chk(CH3_ADDR, 8'h40);
	endtask
	task automatic t_restart;
		@(posedge sys_clk);
		diag_en <= 1'b1;
		perm_fault <= 3'b101;
		rd_chk(CH1_ADDR, 8'h80);
		chk({5'h00, perm_restart_r}, 8'h01);
		rd_chk(CH2_ADDR, 8'h00);
		chk({5'h00, perm_restart_r}, 8'h00);
		rd_chk(CH3_ADDR, 8'h00);
		chk({5'h00, perm_restart_r}, 8'h04);
		@(posedge sys_clk);
		diag_en <= 1'b0;
		rd_chk(CH3_ADDR, 8'h00);
		chk({5'h00, perm_restart_r}, 8'h00);
	endtask

	// event lands in the very cycle of the read: old byte out, set survives
	task automatic t_setwin;
		@(posedge sys_clk);
		evt[0] <= chan_evt_s'(6'h01);
		host.read(CH1_ADDR);
		evt[0] <= '0;
		#1;
		chk(rd_data_r, 8'h80);
		rd_chk(CH1_ADDR, 8'h81);
	endtask
	// mid-run reset: only a reset forgets the tristate history bit
	task automatic t_rerst;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(CH1_ADDR, 8'h00);
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// hang guard: the whole run needs about 160 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 1000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		{rst, diag_en, tri_exit, ton_done, tw, perm_fault} = 11'h400;
		ton_act = 1'b1;
		evt = '0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_flags();
		t_upper();
		t_restart();
		t_setwin();
		t_rerst();
		wrap_up();
	end
endmodule
